// ==== core/ats_pkg.sv ====
/*
  Shared constants and types for the transmit slot source block of the
  audio serial interface. Assumes an 8-bit register port and a bit tick
  from the wider serial interface that is synchronous to the system clock.
*/
package ats_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_PIN_SEL = 8'h1D;
  localparam logic [7:0] ADDR_CH3     = 8'h20;
  localparam logic [7:0] ADDR_CH4     = 8'h21;
  localparam logic [7:0] ADDR_CH5     = 8'h22;

  // Pin choice bit positions in the pin select register.
  localparam int PSEL_CH3_BIT = 2;
  localparam int PSEL_CH4_BIT = 3;
  localparam logic [1:0] PSEL_RST = 2'h0;

  // Source field codes.
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_A   = 2'h1;
  localparam logic [1:0] SRC_B   = 2'h2;
  localparam logic [1:0] SRC_RSV = 2'h3;

  // Channel configuration register layout.
  typedef struct packed {
    logic       rsv;
    logic [1:0] src;
    logic [4:0] slot;
  } ats_cfg_t;

  localparam ats_cfg_t CH3_RST = '{rsv: 1'h0, src: SRC_OFF, slot: 5'h02};
  localparam ats_cfg_t CH4_RST = '{rsv: 1'h0, src: SRC_OFF, slot: 5'h03};
  localparam ats_cfg_t CH5_RST = '{rsv: 1'h0, src: SRC_OFF, slot: 5'h04};

  // Frame formats and word lengths from the wider serial interface.
  typedef enum logic [1:0] {FMT_TDM = 2'h0, FMT_I2S = 2'h1, FMT_LJ = 2'h2} ats_fmt_t;
  typedef enum logic [1:0] {WL16 = 2'h0, WL20 = 2'h1, WL24 = 2'h2, WL32 = 2'h3} ats_wlen_t;
  localparam logic [4:0] LAST16 = 5'h0F;
  localparam logic [4:0] LAST20 = 5'h13;
  localparam logic [4:0] LAST24 = 5'h17;
  localparam logic [4:0] LAST32 = 5'h1F;

  // One-hot slot owner of a data-out pin.
  typedef enum logic [3:0] {
    OWN_NONE = 4'h1, OWN_CH3 = 4'h2, OWN_CH4 = 4'h4, OWN_CH5 = 4'h8
  } ats_own_t;

  // Sample words, MSB aligned.
  typedef struct packed {
    logic [31:0] mic3;
    logic [31:0] mic4;
    logic [31:0] vbat;
    logic [31:0] temp;
    logic [31:0] loop1;
    logic [31:0] echo1;
  } ats_src_t;

  // Framing strobes and the half-frame level.
  typedef struct packed {
    logic bit_tick;
    logic frame_start;
    logic lr;
  } ats_serial_t;

  // Whole state of the block.
  typedef struct packed {
    ats_cfg_t    cfg3;
    ats_cfg_t    cfg4;
    ats_cfg_t    cfg5;
    logic [1:0]  psel;
    logic [7:0]  rdata;
    logic        lr_prev;
    logic [4:0]  bit_cnt;
    logic [4:0]  slot;
    ats_own_t    own1;
    ats_own_t    own2;
    logic [31:0] sh1;
    logic [31:0] sh2;
    logic        d1;
    logic        d2;
    logic        oe1_n;
    logic        oe2_n;
  } ats_state_t;

endpackage

// ==== core/ats_tx_slot.sv ====
/*
  Transmit source and slot assignment for output channels 3, 4 and 5.
  Assumes bit_tick marks each bit clock, frame_start the first bit of a
  TDM frame, and lr the half-frame level in I2S or left-justified mode.
*/
// Summary of operation
// RULE1: Channel 3 source: off, mic3, battery.
// RULE2: Channel 4 source: off, mic4, temperature.
// RULE3: Channel 5 source: off, loopback, echo.
// RULE4: Five-bit slot field picks TDM or half slot.
// RULE5: Bit 7 reserved, reads zero, write ignored.
// RULE6: Channel 4 resets to 0x03.
// RULE7: Channel 5 resets to 0x04.
// RULE8: Channel 3 slot resets to two.
// RULE9: Channels 3, 4 pick first or second pin.
// RULE10: Tri-state channel releases its line all slot.
`timescale 1ns/1ps
module ats_tx_slot
  import ats_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Register port.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Serial framing and samples.
  input  ats_serial_t      ser_i,
  input  ats_fmt_t         fmt_i,
  input  ats_wlen_t        wlen_i,
  input  ats_src_t         src_i,
  // Data-out pins.
  output logic             dout1_o,
  output logic             dout1_oe_n_o,
  output logic             serial_data_out_second_o,
  output logic             serial_data_out_second_oe_n_o
);

  ats_state_t s_r;
  ats_state_t s_nxt;
  logic       restart;
  logic [4:0] bit_now;
  logic [4:0] slot_now;
  logic       ld;
  logic       h3;
  logic       h4;
  logic       h5;

  // Write image of a channel register; bit 7 never stores.
  function automatic ats_cfg_t cfg_w(input logic [7:0] d);
    return '{rsv: 1'h0, src: d[6:5], slot: d[4:0]}; // RULE5
  endfunction

  // Slot match: full index in TDM, half plus index in two-half formats.
  function automatic logic hit(input ats_cfg_t c, input logic [4:0] sl,
                               input logic right, input logic tdm);
    logic act;
    act = (c.src == SRC_A) || (c.src == SRC_B); // RULE10
    if (tdm) begin
      return act && (c.slot == sl); // RULE4
    end
    return act && (c.slot[4] == right) && (c.slot[3:0] == sl[3:0]); // RULE4
  endfunction

  // Sample word picked by a source code; reserved and off give nothing.
  function automatic logic [31:0] pick_src(input logic [1:0] sc, input logic [31:0] a,
                                           input logic [31:0] b);
    if (sc == SRC_A) begin
      return a;
    end else if (sc == SRC_B) begin
      return b;
    end
    return 32'h0;
  endfunction

  // Lower channel numbers win when two share a slot on one pin.
  function automatic ats_own_t pick_own(input logic a3, input logic a4, input logic a5);
    if (a3) begin
      return OWN_CH3;
    end else if (a4) begin
      return OWN_CH4;
    end else if (a5) begin
      return OWN_CH5;
    end
    return OWN_NONE;
  endfunction

  function automatic logic [31:0] word_of(input ats_own_t o, input ats_state_t s,
                                          input ats_src_t x);
    case (o)
      OWN_CH3: return pick_src(s.cfg3.src, x.mic3, x.vbat);   // RULE1
      OWN_CH4: return pick_src(s.cfg4.src, x.mic4, x.temp);   // RULE2
      OWN_CH5: return pick_src(s.cfg5.src, x.loop1, x.echo1); // RULE3
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [4:0] wl_last(input ats_wlen_t w);
    case (w)
      WL16:    return LAST16;
      WL20:    return LAST20;
      WL24:    return LAST24;
      default: return LAST32;
    endcase
  endfunction

  // Next-state logic: register port, slot tracking and shifting.
  always_comb begin
    s_nxt    = s_r;
    restart  = 1'b0;
    bit_now  = s_r.bit_cnt;
    slot_now = s_r.slot;
    ld       = 1'b0;
    h3       = 1'b0;
    h4       = 1'b0;
    h5       = 1'b0;
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CH3) begin
        s_nxt.cfg3 = cfg_w(reg_wdata_i);
      end else if (reg_addr_i == ADDR_CH4) begin
        s_nxt.cfg4 = cfg_w(reg_wdata_i);
      end else if (reg_addr_i == ADDR_CH5) begin
        s_nxt.cfg5 = cfg_w(reg_wdata_i);
      end else if (reg_addr_i == ADDR_PIN_SEL) begin
        s_nxt.psel = {reg_wdata_i[PSEL_CH4_BIT], reg_wdata_i[PSEL_CH3_BIT]}; // RULE9
      end
    end
    // Read data follows the address one cycle later; unmapped reads zero.
    if (reg_addr_i == ADDR_CH3) begin
      s_nxt.rdata = s_r.cfg3;
    end else if (reg_addr_i == ADDR_CH4) begin
      s_nxt.rdata = s_r.cfg4;
    end else if (reg_addr_i == ADDR_CH5) begin
      s_nxt.rdata = s_r.cfg5;
    end else if (reg_addr_i == ADDR_PIN_SEL) begin
      s_nxt.rdata = {4'h0, s_r.psel, 2'h0};
    end else begin
      s_nxt.rdata = 8'h00;
    end
    if (ser_i.bit_tick) begin
      // TDM restarts on frame start; two-half formats restart on each lr edge.
      restart       = (fmt_i == FMT_TDM) ? ser_i.frame_start : (ser_i.lr != s_r.lr_prev);
      s_nxt.lr_prev = ser_i.lr;
      bit_now       = restart ? 5'h00 : s_r.bit_cnt;
      slot_now      = restart ? 5'h00 : s_r.slot;
      ld            = (bit_now == 5'h00);
      if (ld) begin
        h3 = hit(s_r.cfg3, slot_now, ser_i.lr, fmt_i == FMT_TDM);
        h4 = hit(s_r.cfg4, slot_now, ser_i.lr, fmt_i == FMT_TDM);
        h5 = hit(s_r.cfg5, slot_now, ser_i.lr, fmt_i == FMT_TDM);
        s_nxt.own1  = pick_own(h3 && !s_r.psel[0], h4 && !s_r.psel[1], h5); // RULE9
        s_nxt.own2  = pick_own(h3 && s_r.psel[0], h4 && s_r.psel[1], 1'b0); // RULE9
        s_nxt.sh1   = word_of(s_nxt.own1, s_r, src_i);
        s_nxt.sh2   = word_of(s_nxt.own2, s_r, src_i);
        // The enable holds for the whole slot, so an idle slot stays released.
        s_nxt.oe1_n = (s_nxt.own1 == OWN_NONE); // RULE10
        s_nxt.oe2_n = (s_nxt.own2 == OWN_NONE); // RULE10
      end
      s_nxt.d1  = s_nxt.sh1[31];
      s_nxt.d2  = s_nxt.sh2[31];
      s_nxt.sh1 = {s_nxt.sh1[30:0], 1'b0};
      s_nxt.sh2 = {s_nxt.sh2[30:0], 1'b0};
      if (bit_now >= wl_last(wlen_i)) begin
        s_nxt.bit_cnt = 5'h00;
        s_nxt.slot    = slot_now + 5'h01;
      end else begin
        s_nxt.bit_cnt = bit_now + 5'h01;
        s_nxt.slot    = slot_now;
      end
    end
  end

  // State register; pins start released.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r         <= '0;
      s_r.cfg3    <= CH3_RST; // RULE8
      s_r.cfg4    <= CH4_RST; // RULE6
      s_r.cfg5    <= CH5_RST; // RULE7
      s_r.psel    <= PSEL_RST;
      s_r.own1    <= OWN_NONE;
      s_r.own2    <= OWN_NONE;
      s_r.oe1_n   <= 1'b1;
      s_r.oe2_n   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o  = s_r.rdata;
  assign dout1_o      = s_r.d1;
  assign dout1_oe_n_o = s_r.oe1_n;
  assign serial_data_out_second_o      = s_r.d2;
  assign serial_data_out_second_oe_n_o = s_r.oe2_n;

  // Checks. wr_seen marks that software has touched any register.
  logic wr_seen;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_seen <= 1'b0;
    end else if (reg_wr_i) begin
      wr_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  AST_RSV_READ: assert property (reg_rdata_o[7] == 1'b0) // RULE5
    else $error("reserved bit read as one");
  AST_RST_CH4: assert property (!wr_seen |-> s_r.cfg4 == 8'h03 && s_r.cfg4.src == 2'h0) // RULE6
    else $error("channel 4 lost its reset value");
  AST_RST_CH5: assert property (!wr_seen |-> s_r.cfg5 == 8'h04) // RULE7
    else $error("channel 5 lost its reset value");
  AST_RST_CH3: assert property (!wr_seen |-> s_r.cfg3.slot == 5'h02) // RULE8
    else $error("channel 3 slot not two after reset");
  AST_CH3_SRC: assert property (ld && s_nxt.own1 == OWN_CH3 && s_r.cfg3.src == 2'h2
                                |=> dout1_o == $past(src_i.vbat[31])) // RULE1
    else $error("channel 3 did not send battery data");
  AST_CH4_SRC: assert property (ld && s_nxt.own1 == OWN_CH4 && s_r.cfg4.src == 2'h1
                                |=> dout1_o == $past(src_i.mic4[31])) // RULE2
    else $error("channel 4 did not send mic data");
  AST_CH5_SRC: assert property (ld && s_nxt.own1 == OWN_CH5 && s_r.cfg5.src == 2'h2
                                |=> dout1_o == $past(src_i.echo1[31])) // RULE3
    else $error("channel 5 did not send echo data");
  AST_SLOT_TDM: assert property (ld && fmt_i == FMT_TDM && s_nxt.own1 == OWN_CH4
                                 |-> slot_now == s_r.cfg4.slot) // RULE4
    else $error("channel 4 placed in wrong slot");
  AST_WR_RSV: assert property (reg_wr_i && reg_addr_i == 8'h21
                               |=> s_r.cfg4.rsv == 1'b0 && s_r.cfg4.slot == $past(reg_wdata_i[4:0])) // RULE5
    else $error("channel 4 write stored wrongly");
  // Judged only at the slot load, since a late pin select write leaves the slot driven.
  AST_PIN2: assert property ($past(ld) && !serial_data_out_second_oe_n_o |-> $past(s_r.psel) != 2'h0) // RULE9
    else $error("second pin driven with no channel routed");
  AST_RELEASE: assert property (ld && !h3 && !h4 && !h5 |=> dout1_oe_n_o && serial_data_out_second_oe_n_o) // RULE10
    else $error("pin driven in an unowned slot");

  COV_CH3_DRIVE: cover property (ld && s_nxt.own1 == OWN_CH3 ##1 !dout1_oe_n_o);
  COV_PIN2: cover property (!serial_data_out_second_oe_n_o);
  COV_RIGHT: cover property (ld && fmt_i == FMT_I2S && ser_i.lr && s_nxt.own1 != OWN_NONE);
  COV_CH5: cover property (ld && s_nxt.own1 == OWN_CH5);

endmodule

// ==== tb/ats_host_rx.sv ====
/*
  Host receiver model for the two data-out pins of the slot source block.
  Assumes one bit is taken in the cycle after each bit tick.
*/
`timescale 1ns/1ps
module ats_host_rx (
  // Clock and control.
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        clr_i,
  input  wire logic        tick_i,
  // Device pins, enables active low.
  input  wire logic [1:0]  dout_i,
  input  wire logic [1:0]  oe_n_i,
  // Received words, driven bit counts and first driven tick.
  output logic [1:0][15:0] word_o,
  output logic [1:0][7:0]  cnt_o,
  output logic      [15:0] first_o
);
  logic        tick_d_r;
  logic [15:0] tcnt_r;

  // Sampling lags the tick by one cycle because the device pins are registered.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_d_r <= 1'b0;
      tcnt_r   <= 16'h0000;
      word_o   <= '0;
      cnt_o    <= '0;
      first_o  <= 16'hFFFF;
    end else if (clr_i) begin
      tick_d_r <= 1'b0;
      tcnt_r   <= 16'h0000;
      word_o   <= '0;
      cnt_o    <= '0;
      first_o  <= 16'hFFFF;
    end else begin
      tick_d_r <= tick_i;
      if (tick_d_r) begin
        tcnt_r <= tcnt_r + 16'h0001;
        for (int p = 0; p < 2; p++) begin
          if (!oe_n_i[p]) begin
            word_o[p] <= {word_o[p][14:0], dout_i[p]};
            cnt_o[p]  <= cnt_o[p] + 8'h01;
            if (cnt_o == '0) first_o <= tcnt_r;
          end
        end
      end
    end
  end
endmodule

// ==== tb/test_asi_tx_ch3_to_ch5_slot_source.sv ====
/*
  Self-checking bench for the channel 3 to 5 slot source block.
  Assumes the host model ats_host_rx; the word length varies per scenario.
*/
`timescale 1ns/1ps
module test_asi_tx_ch3_to_ch5_slot_source
  import ats_pkg::*;
;
  logic             clk_sys_i = 1'b0;
  logic             nrst_i;
  logic [7:0]       addr;
  logic [7:0]       wdata;
  logic [7:0]       rdata;
  logic             wr;
  logic             clr;
  ats_serial_t      ser;
  ats_fmt_t         fmt;
  ats_wlen_t        wlen;
  ats_src_t         src;
  logic [1:0]       dout;
  logic [1:0]       oe_n;
  logic [1:0][15:0] word;
  logic [1:0][7:0]  cnt;
  logic [15:0]      first;
  int               miscompares = 0;
  int               samples_checked = 0;
  logic [31:0]      seed = 32'h0000_0037;

  // Free-running system clock.
  always #50 clk_sys_i = ~clk_sys_i;

  ats_tx_slot u_dut (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .reg_addr_i  (addr),
    .reg_wr_i    (wr),
    .reg_wdata_i (wdata),
    .reg_rdata_o (rdata),
    .ser_i       (ser),
    .fmt_i       (fmt),
    .wlen_i      (wlen),
    .src_i       (src),
    .dout1_o     (dout[0]),
    .dout1_oe_n_o(oe_n[0]),
    .serial_data_out_second_o     (dout[1]),
    .serial_data_out_second_oe_n_o(oe_n[1])
  );

  ats_host_rx u_host (
    .clk_sys_i(clk_sys_i),
    .nrst_i   (nrst_i),
    .clr_i    (clr),
    .tick_i   (ser.bit_tick),
    .dout_i   (dout),
    .oe_n_i   (oe_n),
    .word_o   (word),
    .cnt_o    (cnt),
    .first_o  (first)
  );

  // Xorshift source of repeatable stimulus.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected sample word for a channel and source code.
  function automatic logic [31:0] pick(input int ch, input logic [1:0] c, input ats_src_t s);
    case (ch)
      3: pick = (c == SRC_A) ? s.mic3 : s.vbat;
      4: pick = (c == SRC_A) ? s.mic4 : s.temp;
      default: pick = (c == SRC_A) ? s.loop1 : s.echo1;
    endcase
  endfunction

  // Bits per slot for a word length code.
  function automatic int wl_bits(input ats_wlen_t w);
    if (w == WL32) begin
      return 32;
    end
    return 16 + 4 * int'(w);
  endfunction

  // Tick index at which a slot field starts; the two-half frames open right.
  function automatic int first_tick(input logic tdm, input logic [4:0] sl, input int bits);
    if (tdm) begin
      return sl * bits;
    end
    return (sl[4] ? 0 : 256) + sl[3:0] * bits;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One-cycle write strobe, released after the edge that takes it.
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_sys_i);
    #1;
    wr = 1'b0;
  endtask

  // Read data follows the sampled address by one edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    #1;
    addr = a;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({24'h0, rdata}, {24'h0, e}, "register read");
  endtask

  // One frame of 512 ticks, one every other cycle; I2S and LJ open right.
  task automatic frame(input logic tdm);
    for (int i = 0; i < 512; i++) begin
      @(posedge clk_sys_i);
      #1;
      ser.bit_tick = 1'b1;
      ser.frame_start = tdm && (i == 0);
      ser.lr = !tdm && (i < 256);
      @(posedge clk_sys_i);
      #1;
      ser.bit_tick = 1'b0;
    end
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  // Guard against a hang.
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    miscompares++;
    stop_test();
  end

  // Register checks, then one frame per channel and source code.
  initial begin
    logic [31:0] v;
    logic [31:0] e;
    logic [4:0]  sl;
    logic        p2;
    logic        drv;
    int          n;
    int          bits;
    {addr, wdata, wr, clr, ser} = '0;
    fmt = FMT_TDM;
    wlen = WL16;
    src = '0;
    n = 0;
    nrst_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    #1;
    nrst_i = 1'b1;
    rd(ADDR_CH3, 8'h02);
    rd(ADDR_CH4, 8'h03);
    rd(ADDR_CH5, 8'h04);
    rd(ADDR_PIN_SEL, 8'h00);
    rd(8'h30, 8'h00);
    for (int a = 0; a < 3; a++) begin
      v = xs();
      wrr(ADDR_CH3 + 8'(a), v[7:0] & 8'h7F);
      rd(ADDR_CH3 + 8'(a), v[7:0] & 8'h7F);
    end
    wrr(ADDR_PIN_SEL, 8'hFF);
    rd(ADDR_PIN_SEL, 8'h0C);
    for (int ch = 3; ch <= 5; ch++) begin
      for (int c = 0; c < 4; c++) begin
        v = xs();
        n++;
        src = {xs(), xs(), xs(), xs(), xs(), xs()};
        fmt = v[1] ? FMT_TDM : (v[0] ? FMT_I2S : FMT_LJ);
        wlen = (n > 3) ? ats_wlen_t'(v[11:10]) : WL16;
        bits = wl_bits(wlen);
        sl = (n == 2) ? 5'h1F : ((n == 3) ? 5'h00 : v[8:4]);
        // Longer words keep the slot inside the frame or half so it sends whole.
        if (wlen != WL16) begin
          sl = (fmt == FMT_TDM) ? {1'b0, v[7:4]} : {v[8], 1'b0, v[6:4]};
        end
        p2 = v[9] && (ch != 5);
        wrr(ADDR_CH3, 8'h00);
        wrr(ADDR_CH4, 8'h00);
        wrr(ADDR_CH5, 8'h00);
        wrr(ADDR_PIN_SEL, {4'h0, v[9], v[9], 2'h0});
        wrr(ADDR_CH3 + 8'(ch - 3), {1'b0, 2'(c), sl});
        clr = 1'b1;
        @(posedge clk_sys_i);
        #1;
        clr = 1'b0;
        frame(fmt == FMT_TDM);
        drv = (c == 1) || (c == 2);
        // The host keeps the last 16 bits it took, so align the word to them.
        e = pick(ch, 2'(c), src) >> (32 - bits);
        check({24'h0, cnt[0]}, (drv && !p2) ? 32'(bits) : 32'h0, "pin one bits");
        check({24'h0, cnt[1]}, (drv && p2) ? 32'(bits) : 32'h0, "pin two bits");
        if (drv) begin
          check({16'h0, word[p2]}, {16'h0, e[15:0]}, "word");
          check({16'h0, first}, 32'(first_tick(fmt == FMT_TDM, sl, bits)),
                "slot start");
        end
      end
    end
    // A second reset in mid-run must bring every register back.
    nrst_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    nrst_i = 1'b1;
    rd(ADDR_CH3, 8'h02);
    rd(ADDR_CH4, 8'h03);
    rd(ADDR_CH5, 8'h04);
    rd(ADDR_PIN_SEL, 8'h00);
    stop_test();
  end
endmodule
